/* File: hdl/tmcap_pkg.sv */
package tmcap_pkg;

    // internal source advances once per instruction cycle of four clocks
    localparam int unsigned  INSTR_CLOCKS   = 4;
    localparam logic [1:0]   INSTR_DIV_LAST = 2'(INSTR_CLOCKS - 1);

    // register indices; byte address is four times the index
    localparam logic [5:0]   IDX_CTRL       = 6'h16;
    localparam logic [5:0]   IDX_PERIOD_A   = 6'h17;
    localparam logic [5:0]   IDX_PERIOD_B   = 6'h18;
    localparam logic [5:0]   IDX_COUNT_A    = 6'h19;
    localparam logic [5:0]   IDX_COUNT_B    = 6'h1A;
    localparam logic [5:0]   IDX_WIDE_LOW   = 6'h1B;
    localparam logic [5:0]   IDX_WIDE_HIGH  = 6'h1C;
    localparam logic [5:0]   IDX_WPCA_LOW   = 6'h1D;
    localparam logic [5:0]   IDX_WPCA_HIGH  = 6'h1E;
    localparam logic [5:0]   IDX_CAPB_LOW   = 6'h1F;
    localparam logic [5:0]   IDX_CAPB_HIGH  = 6'h20;
    localparam logic [5:0]   IDX_STATUS     = 6'h21;
    localparam logic [5:0]   IDX_MASK       = 6'h22;
    localparam logic [5:0]   IDX_MODE       = 6'h23;

    // timer_capture_control fields
    localparam int unsigned  CTRL_CS_A      = 0;
    localparam int unsigned  CTRL_CS_B      = 1;
    localparam int unsigned  CTRL_CS_WIDE   = 2;
    localparam int unsigned  CTRL_COMBINE   = 3;
    localparam int unsigned  CTRL_CAPA_LSB  = 4;
    localparam int unsigned  CTRL_CAPB_LSB  = 6;
    localparam logic [7:0]   CTRL_RESET     = 8'h00;

    // status and mask layout
    localparam int unsigned  ST_OVF_A       = 0;
    localparam int unsigned  ST_OVF_B       = 1;
    localparam int unsigned  ST_OVF_WIDE    = 2;
    localparam int unsigned  ST_CAP_A       = 3;
    localparam int unsigned  ST_CAP_B       = 4;
    localparam int unsigned  ST_WIDTH       = 5;
    localparam logic [4:0]   STATUS_RESET   = 5'h00;
    localparam logic [4:0]   MASK_RESET     = 5'h00;

    // mode register: bit 0 turns the wide period pair into capture A
    localparam int unsigned  MODE_CAPA_EN   = 0;
    localparam logic [0:0]   MODE_RESET     = 1'h0;

    localparam logic [7:0]   PERIOD_RESET   = 8'hFF;
    localparam logic [15:0]  WPCA_RESET     = 16'hFFFF;

    localparam logic [3:0]   RISE4_LAST     = 4'h3;
    localparam logic [3:0]   RISE16_LAST    = 4'hF;

    typedef enum logic [1:0] {
        EDGE_FALL,
        EDGE_RISE,
        EDGE_RISE4,
        EDGE_RISE16
    } tmcap_edge_e;

endpackage

/* File: hdl/tmcap_capev.sv */
`timescale 1ns/1ns
`default_nettype none
module tmcap_capev
    import tmcap_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       pin,
    input  wire logic [1:0] mode,
    output logic            event_p
);

    logic       prev_r;
    logic [3:0] rise_cnt_r;
    logic       rise;
    logic       fall;

    assign rise = pin & ~prev_r;
    assign fall = ~pin & prev_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            prev_r <= 1'b0;
        else
            prev_r <= pin;
    end

    // prescaler keeps counting across mode changes; software
    // should expect a partial first group after switching
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rise_cnt_r <= 4'h0;
        else if (rise)
            rise_cnt_r <= rise_cnt_r + 4'h1;
    end

    always_comb
    begin
        case (tmcap_edge_e'(mode))
            EDGE_FALL:   event_p = fall;
            EDGE_RISE:   event_p = rise;
            EDGE_RISE4:  event_p = rise && (rise_cnt_r[1:0] == RISE4_LAST[1:0]);
            EDGE_RISE16: event_p = rise && (rise_cnt_r == RISE16_LAST);
            default:     event_p = 1'b0;
        endcase
    end

    chk_fall_mode_event: assert property ( // R12
        @(posedge clock) disable iff (!rst_n)
        (mode == 2'h0 && prev_r && !pin) |-> event_p)
        else $error("falling edge did not raise capture event");

    chk_every_fourth: assert property ( // R13
        @(posedge clock) disable iff (!rst_n)
        (mode == 2'h2 && event_p) |-> (rise && rise_cnt_r[1:0] == 2'h3))
        else $error("divide-by-four capture at wrong edge");

    chk_every_sixteenth: assert property ( // R12
        @(posedge clock) disable iff (!rst_n)
        (mode == 2'h3 && event_p) |-> (rise && rise_cnt_r == 4'hF))
        else $error("divide-by-sixteen capture at wrong edge");

endmodule // tmcap_capev
`default_nettype wire

/* File: hdl/tmcap_top.sv */
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1 - two independent 8-bit up-counters, each with period register and overflow flag
// R2 - internal source advances counters once per instruction cycle, a quarter of clock
// R3 - external mode advances 8-bit counters on falling edges of shared clock pin
// R4 - combine bit 3 chains both counters into one 16-bit timer
// R5 - the two 8-bit counters provide the pwm time base
// R6 - third timer is a 16-bit up-counter in high and low byte registers
// R7 - one 16-bit pair is third timer period or capture A result
// R8 - second pair holds capture B results; third timer is capture time base
// R9 - bit 2 selects wide timer source: external falling edge or internal
// R10 - bit 1 selects counter B source: shared pin falling edge or internal
// R11 - bit 0 selects counter A source: shared pin falling edge or internal
// R12 - capture B mode bits 7-6: fall, rise, every 4th, every 16th rise
// R13 - capture A mode bits 5-4 use the same edge encoding
// R14 - control register fully read/write, cleared to zero by reset
// R15 - counter matching its period returns to zero next increment, sets flag
// R16 - qualifying capture event copies wide timer into that channel's pair
module tmcap_top
    import tmcap_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        shared_ext_clock_pin,
    input  wire logic        wide_ext_clock_pin,
    input  wire logic        cap_a_pin,
    input  wire logic        cap_b_pin,
    output logic      [7:0]  pwm_base_a,
    output logic      [7:0]  pwm_base_b,
    output logic             pwm_wrap_a,
    output logic             pwm_wrap_b,
    output logic             irq
);

    function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
        return (a[1:0] == 2'b00) && (a[7:2] == idx);
    endfunction

    logic                ack_r;
    logic [31:0]         readdata_r;
    logic [31:0]         rd_mux;
    logic                wr_go;
    logic [7:0]          wd;
    logic [7:0]          ctrl_r;
    logic [7:0]          period_a_r;
    logic [7:0]          period_b_r;
    logic [7:0]          count_a_r;
    logic [7:0]          count_b_r;
    logic [15:0]         wide_r;
    logic [15:0]         wpca_r;
    logic [15:0]         capb_r;
    logic [ST_WIDTH-1:0] status_r;
    logic [ST_WIDTH-1:0] mask_r;
    logic [ST_WIDTH-1:0] events;
    logic [0:0]          mode_r;
    logic [1:0]          div_r;
    logic                tick;
    logic                shared_prev_r;
    logic                wide_prev_r;
    logic                shared_fall;
    logic                wide_fall;
    logic                combine;
    logic                inc_a;
    logic                inc_b;
    logic                inc_w;
    logic                match_a;
    logic                match_b;
    logic                match16;
    logic                cap_a_en;
    logic                ev_ovf_a;
    logic                ev_ovf_b;
    logic                ev_ovf_w;
    logic [1:0]          cap_ev;
    logic [1:0]          cap_pins;
    logic                wrap_a_r;
    logic                wrap_b_r;
    logic                wr_cnt_a;
    logic                wr_cnt_b;
    logic                wr_wide_lo;
    logic                wr_wide_hi;

    // one wait state: request is taken in its first cycle, answered in the second
    assign waitrequest = (read | write) & ~ack_r;
    assign wr_go       = write & ack_r;
    assign wd          = writedata[7:0];
    assign readdata    = readdata_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ack_r <= 1'b0;
        else
            ack_r <= (read | write) & ~ack_r;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            readdata_r <= 32'h0;
        else if (read && !ack_r)
            readdata_r <= rd_mux;
    end

    always_comb
    begin
        rd_mux = 32'h0;
        if (address[1:0] == 2'b00)
        begin
            case (address[7:2])
                IDX_CTRL:      rd_mux = {24'h0, ctrl_r};
                IDX_PERIOD_A:  rd_mux = {24'h0, period_a_r};
                IDX_PERIOD_B:  rd_mux = {24'h0, period_b_r};
                IDX_COUNT_A:   rd_mux = {24'h0, count_a_r};
                IDX_COUNT_B:   rd_mux = {24'h0, count_b_r};
                IDX_WIDE_LOW:  rd_mux = {24'h0, wide_r[7:0]};
                IDX_WIDE_HIGH: rd_mux = {24'h0, wide_r[15:8]};
                IDX_WPCA_LOW:  rd_mux = {24'h0, wpca_r[7:0]};
                IDX_WPCA_HIGH: rd_mux = {24'h0, wpca_r[15:8]};
                IDX_CAPB_LOW:  rd_mux = {24'h0, capb_r[7:0]};
                IDX_CAPB_HIGH: rd_mux = {24'h0, capb_r[15:8]};
                IDX_STATUS:    rd_mux = {27'h0, status_r};
                IDX_MASK:      rd_mux = {27'h0, mask_r};
                IDX_MODE:      rd_mux = {31'h0, mode_r};
                default:       rd_mux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctrl_r <= CTRL_RESET; // R14
        else if (wr_go && hit(address, IDX_CTRL))
            ctrl_r <= wd; // R14
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            period_a_r <= PERIOD_RESET;
            period_b_r <= PERIOD_RESET;
            mask_r     <= MASK_RESET;
            mode_r     <= MODE_RESET;
        end
        else if (wr_go)
        begin
            if (hit(address, IDX_PERIOD_A))
                period_a_r <= wd;
            if (hit(address, IDX_PERIOD_B))
                period_b_r <= wd;
            if (hit(address, IDX_MASK))
                mask_r <= wd[ST_WIDTH-1:0];
            if (hit(address, IDX_MODE))
                mode_r <= wd[0:0];
        end
    end

    // instruction-cycle prescaler
    assign tick = (div_r == INSTR_DIV_LAST); // R2

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            div_r <= 2'h0;
        else
            div_r <= div_r + 2'h1; // R2
    end

    // pins are synchronous to clock, so one flop suffices for edge detection
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            shared_prev_r <= 1'b0;
            wide_prev_r   <= 1'b0;
        end
        else
        begin
            shared_prev_r <= shared_ext_clock_pin;
            wide_prev_r   <= wide_ext_clock_pin;
        end
    end

    assign shared_fall = shared_prev_r & ~shared_ext_clock_pin; // R3
    assign wide_fall   = wide_prev_r & ~wide_ext_clock_pin;
    assign combine     = ctrl_r[CTRL_COMBINE];
    assign inc_a       = ctrl_r[CTRL_CS_A] ? shared_fall : tick; // R11
    assign inc_b       = ctrl_r[CTRL_CS_B] ? shared_fall : tick; // R10
    assign inc_w       = ctrl_r[CTRL_CS_WIDE] ? wide_fall : tick; // R9
    assign match_a     = (count_a_r == period_a_r);
    assign match_b     = (count_b_r == period_b_r);
    assign match16     = match_a && match_b;
    assign cap_a_en    = mode_r[MODE_CAPA_EN];
    assign wr_cnt_a    = wr_go && hit(address, IDX_COUNT_A);
    assign wr_cnt_b    = wr_go && hit(address, IDX_COUNT_B);
    assign wr_wide_lo  = wr_go && hit(address, IDX_WIDE_LOW);
    assign wr_wide_hi  = wr_go && hit(address, IDX_WIDE_HIGH);

    // in combined mode counter B counts only on counter A carry
    assign ev_ovf_a = !combine && inc_a && match_a; // R15
    assign ev_ovf_b = combine ? (inc_a && match16) : (inc_b && match_b); // R4
    assign ev_ovf_w = inc_w && (cap_a_en ? (wide_r == 16'hFFFF) : (wide_r == wpca_r));

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            count_a_r <= 8'h00;
        else if (wr_cnt_a)
            count_a_r <= wd;
        else if (combine && inc_a)
            count_a_r <= match16 ? 8'h00 : count_a_r + 8'h01; // R4
        else if (!combine && inc_a)
            count_a_r <= match_a ? 8'h00 : count_a_r + 8'h01; // R1 R15
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            count_b_r <= 8'h00;
        else if (wr_cnt_b)
            count_b_r <= wd;
        else if (combine && inc_a)
        begin
            if (match16)
                count_b_r <= 8'h00; // R4
            else if (count_a_r == 8'hFF)
                count_b_r <= count_b_r + 8'h01; // R4
        end
        else if (!combine && inc_b)
            count_b_r <= match_b ? 8'h00 : count_b_r + 8'h01; // R1 R15
    end

    // pwm time base taps; wrap pulses are registered copies of the overflow events
    assign pwm_base_a = count_a_r; // R5
    assign pwm_base_b = count_b_r; // R5
    assign pwm_wrap_a = wrap_a_r;
    assign pwm_wrap_b = wrap_b_r;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wrap_a_r <= 1'b0;
            wrap_b_r <= 1'b0;
        end
        else
        begin
            wrap_a_r <= ev_ovf_a; // R5
            wrap_b_r <= ev_ovf_b; // R5
        end
    end

    // in capture mode the wide timer free-runs over the full 16 bits
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            wide_r <= 16'h0000;
        else if (wr_wide_lo)
            wide_r[7:0] <= wd;
        else if (wr_wide_hi)
            wide_r[15:8] <= wd;
        else if (inc_w)
            wide_r <= ev_ovf_w ? 16'h0000 : wide_r + 16'h0001; // R6 R15
    end

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_cap
            tmcap_capev u_capev (
                .clock   (clock),
                .rst_n   (rst_n),
                .pin     (cap_pins[i]),
                .mode    (ctrl_r[CTRL_CAPA_LSB + 2 * i +: 2]), // R12 R13
                .event_p (cap_ev[i])
            );
        end
    endgenerate

    assign cap_pins = {cap_b_pin, cap_a_pin};

    // a capture outranks a software write landing in the same cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            wpca_r <= WPCA_RESET;
        else if (cap_a_en && cap_ev[0])
            wpca_r <= wide_r; // R7 R16
        else if (wr_go && hit(address, IDX_WPCA_LOW))
            wpca_r[7:0] <= wd; // R7
        else if (wr_go && hit(address, IDX_WPCA_HIGH))
            wpca_r[15:8] <= wd; // R7
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            capb_r <= 16'h0000;
        else if (cap_ev[1])
            capb_r <= wide_r; // R8 R16
    end

    always_comb
    begin
        events              = '0;
        events[ST_OVF_A]    = ev_ovf_a; // R1
        events[ST_OVF_B]    = ev_ovf_b; // R1
        events[ST_OVF_WIDE] = ev_ovf_w;
        events[ST_CAP_A]    = cap_a_en && cap_ev[0];
        events[ST_CAP_B]    = cap_ev[1];
    end

    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            status_r <= STATUS_RESET;
        else if (wr_go && hit(address, IDX_STATUS))
            status_r <= (status_r & ~wd[ST_WIDTH-1:0]) | events; // R15
        else
            status_r <= status_r | events; // R15
    end

    assign irq = |(status_r & mask_r);

    chk_tick_spacing: assert property ( // R2
        @(posedge clock) disable iff (!rst_n)
        tick |=> !tick [*3] ##1 tick)
        else $error("instruction tick not one in four clocks");

    chk_ctrl_cleared: assert property ( // R14
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> (ctrl_r == 8'h00 && count_a_r == 8'h00))
        else $error("control not zero after reset");

    chk_a_wrap_flag: assert property ( // R15
        @(posedge clock) disable iff (!rst_n)
        (!combine && inc_a && match_a && !wr_cnt_a)
            |=> (count_a_r == 8'h00 && status_r[0] && pwm_wrap_a))
        else $error("counter A did not wrap and flag on period match");

    chk_a_ext_edge: assert property ( // R11
        @(posedge clock) disable iff (!rst_n)
        (ctrl_r[0] && !combine && shared_prev_r && !shared_ext_clock_pin
            && !match_a && !wr_cnt_a) |=> (count_a_r == $past(count_a_r) + 8'h01))
        else $error("counter A missed shared pin falling edge");

    chk_a_ext_hold: assert property ( // R3
        @(posedge clock) disable iff (!rst_n)
        (ctrl_r[0] && !combine && !(shared_prev_r && !shared_ext_clock_pin)
            && !wr_cnt_a && !wr_cnt_b) |=> (count_a_r == $past(count_a_r)))
        else $error("counter A moved without an external edge");

    chk_b_internal: assert property ( // R10
        @(posedge clock) disable iff (!rst_n)
        (!ctrl_r[1] && !combine && tick && !match_b && !wr_cnt_b)
            |=> (count_b_r == $past(count_b_r) + 8'h01))
        else $error("counter B missed instruction tick");

    chk_combined_count: assert property ( // R4
        @(posedge clock) disable iff (!rst_n)
        (combine && inc_a && !match16 && !wr_cnt_a && !wr_cnt_b)
            |=> ({count_b_r, count_a_r} == $past({count_b_r, count_a_r}) + 16'h0001))
        else $error("combined 16-bit count did not advance by one");

    chk_wide_ext_edge: assert property ( // R9
        @(posedge clock) disable iff (!rst_n)
        (ctrl_r[2] && wide_prev_r && !wide_ext_clock_pin && !ev_ovf_w
            && !wr_wide_lo && !wr_wide_hi) |=> (wide_r == $past(wide_r) + 16'h0001))
        else $error("wide timer missed its pin falling edge");

    chk_cap_a_copy: assert property ( // R7
        @(posedge clock) disable iff (!rst_n)
        (cap_a_en && cap_ev[0]) |=> (wpca_r == $past(wide_r) && status_r[3]))
        else $error("capture A did not take the wide timer value");

    chk_cap_b_copy: assert property ( // R16
        @(posedge clock) disable iff (!rst_n)
        cap_ev[1] |=> (capb_r == $past(wide_r) && status_r[4]))
        else $error("capture B did not take the wide timer value");

    chk_bus_one_wait: assert property (
        @(posedge clock) disable iff (!rst_n)
        ((read || write) && !ack_r) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not in second cycle");

endmodule // tmcap_top
`default_nettype wire

/* File: verification/tmcap_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tmcap_pin_model
(
    input  wire logic clock,
    output logic      shared_ext_clock_pin,
    output logic      wide_ext_clock_pin,
    output logic      cap_a_pin,
    output logic      cap_b_pin
);
    initial
    begin
        shared_ext_clock_pin = 1'b1;
        wide_ext_clock_pin   = 1'b1;
        cap_a_pin            = 1'b0;
        cap_b_pin            = 1'b0;
    end

    // each level held two clocks so the input sampler cannot miss it
    task automatic ext_pulses(input int sel, input int n);
        repeat (n)
        begin
            repeat (2) @(posedge clock);
            if (sel == 0)
                shared_ext_clock_pin <= 1'b0;
            else
                wide_ext_clock_pin <= 1'b0;
            repeat (2) @(posedge clock);
            shared_ext_clock_pin <= 1'b1;
            wide_ext_clock_pin   <= 1'b1;
        end
    endtask

    task automatic cap_drive(input logic v);
        @(posedge clock);
        cap_a_pin <= v;
        cap_b_pin <= v;
        repeat (6) @(posedge clock);
    endtask
endmodule // tmcap_pin_model
`default_nettype wire

/* File: verification/timers_and_captures_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module timers_and_captures_test
    import tmcap_pkg::*;
;
    logic        clock     = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  address   = 8'h00;
    logic        read      = 1'b0;
    logic        write     = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        sh_pin, wd_pin, ca_pin, cb_pin;
    logic [7:0]  pwm_base_a, pwm_base_b, s0, s1;
    logic        pwm_wrap_a, pwm_wrap_b, irq, e;
    logic [31:0] rd;
    int          errors = 0;
    int          n_checks = 0;
    int          seed = 32'h745D78D2;
    int          n, rises = 0;
    int          wraps_b = 0;

    tmcap_top i_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .shared_ext_clock_pin(sh_pin),
        .wide_ext_clock_pin(wd_pin), .cap_a_pin(ca_pin), .cap_b_pin(cb_pin),
        .pwm_base_a(pwm_base_a), .pwm_base_b(pwm_base_b), .pwm_wrap_a(pwm_wrap_a),
        .pwm_wrap_b(pwm_wrap_b), .irq(irq));
    tmcap_pin_model i_pins (.clock(clock), .shared_ext_clock_pin(sh_pin),
        .wide_ext_clock_pin(wd_pin), .cap_a_pin(ca_pin), .cap_b_pin(cb_pin));

    initial
    begin
        forever #2 clock = ~clock;
    end

    // the wrap output stands one cycle only, so count it as it passes
    always @(posedge clock)
    begin
        if (pwm_wrap_b === 1'b1)
            wraps_b <= wraps_b + 1;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // request held until a rising edge with waitrequest low
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int k;
        @(posedge clock);
        address   <= {idx, 2'b00};
        writedata <= {24'h0, wd};
        read      <= !wr;
        write     <= wr;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clock);
            if (waitrequest === 1'b0)
                break;
        end
        if (k == 50)
        begin
            errors++;
            end_sim();
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // the write lands at this edge; callers look at outputs once it has settled
        @(negedge clock);
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        `CHK(rd, {24'h0, exp})
    endtask

    function automatic logic cap_exp(input logic [1:0] m, input logic rise, input int r);
        case (m)
            EDGE_FALL:  return !rise;
            EDGE_RISE:  return rise;
            EDGE_RISE4: return rise && (r % 4 == 0);
            default:    return rise && (r % 16 == 0);
        endcase
    endfunction

    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(IDX_CTRL, CTRL_RESET);
        rdchk(IDX_PERIOD_A, PERIOD_RESET);
        rdchk(IDX_STATUS, 8'h00);
        rdchk(IDX_WPCA_LOW, 8'hFF);
        rdchk(6'h3F, 8'h00);
        bus(1'b1, 6'h3F, 8'h55);
        rdchk(IDX_CTRL, CTRL_RESET);
        // internal source: ten steps in forty clocks
        @(negedge clock);
        s0 = pwm_base_a;
        s1 = pwm_base_b;
        repeat (40) @(negedge clock);
        `CHK(8'(pwm_base_a - s0), 8'd10)
        `CHK(8'(pwm_base_b - s1), 8'd10)
        repeat (4)
        begin
            n = $random(seed);
            bus(1'b1, IDX_CTRL, n[7:0]);
            rdchk(IDX_CTRL, n[7:0]);
        end
        n = 1 + ($unsigned($random(seed)) % 8);
        bus(1'b1, IDX_CTRL, 8'h03);
        s0 = pwm_base_a;
        s1 = pwm_base_b;
        i_pins.ext_pulses(0, n);
        repeat (4) @(posedge clock);
        `CHK(8'(pwm_base_a - s0), 8'(n))
        `CHK(8'(pwm_base_b - s1), 8'(n))
        bus(1'b1, IDX_CTRL, 8'h04);
        bus(1'b0, IDX_WIDE_LOW, 8'h00);
        s0 = rd[7:0];
        i_pins.ext_pulses(1, n);
        rdchk(IDX_WIDE_LOW, 8'(s0 + n));
        // wide period pair as the limit: 0, 1, 2, then back to 0 with its flag
        bus(1'b1, IDX_WIDE_HIGH, 8'h00);
        bus(1'b1, IDX_WIDE_LOW, 8'h00);
        bus(1'b1, IDX_WPCA_HIGH, 8'h00);
        bus(1'b1, IDX_WPCA_LOW, 8'h02);
        bus(1'b1, IDX_STATUS, 8'h1F);
        i_pins.ext_pulses(1, 3);
        rdchk(IDX_WIDE_LOW, 8'h00);
        bus(1'b0, IDX_STATUS, 8'h00);
        `CHK(rd[2], 1'b1)
        // period match, wrap, flag and interrupt
        bus(1'b1, IDX_CTRL, 8'h01);
        bus(1'b1, IDX_PERIOD_A, 8'h05);
        bus(1'b1, IDX_COUNT_A, 8'h00);
        bus(1'b1, IDX_STATUS, 8'h1F);
        bus(1'b1, IDX_MASK, 8'h01);
        i_pins.ext_pulses(0, 5);
        repeat (4) @(posedge clock);
        `CHK(pwm_base_a, 8'h05)
        `CHK(irq, 1'b0)
        i_pins.ext_pulses(0, 1);
        repeat (4) @(posedge clock);
        `CHK(pwm_base_a, 8'h00)
        `CHK(irq, 1'b1)
        bus(1'b1, IDX_MASK, 8'h00);
        `CHK(irq, 1'b0)
        bus(1'b1, IDX_MASK, 8'h01);
        `CHK(irq, 1'b1)
        bus(1'b1, IDX_STATUS, 8'h01);
        `CHK(irq, 1'b0)
        // combined 16-bit counter carries from A into B
        bus(1'b1, IDX_CTRL, 8'h09);
        bus(1'b1, IDX_PERIOD_A, 8'hFF);
        bus(1'b1, IDX_COUNT_A, 8'hFE);
        bus(1'b1, IDX_COUNT_B, 8'h00);
        i_pins.ext_pulses(0, 3);
        repeat (4) @(posedge clock);
        `CHK({pwm_base_b, pwm_base_a}, 16'h0101)
        // combined pair matches {period_b, period_a}: one wrap, only the B flag
        bus(1'b1, IDX_PERIOD_A, 8'h01);
        bus(1'b1, IDX_PERIOD_B, 8'h01);
        bus(1'b1, IDX_STATUS, 8'h1F);
        n = wraps_b;
        i_pins.ext_pulses(0, 1);
        repeat (4) @(posedge clock);
        `CHK({pwm_base_b, pwm_base_a}, 16'h0000)
        `CHK(wraps_b - n, 1)
        bus(1'b0, IDX_STATUS, 8'h00);
        `CHK(rd[1:0], 2'b10)
        // captures: wide timer frozen on its idle external pin
        bus(1'b1, IDX_MODE, 8'h01);
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, IDX_CTRL, {m[1:0], m[1:0], 4'b0100});
            bus(1'b1, IDX_WIDE_LOW, 8'(8'h30 + m));
            bus(1'b1, IDX_WIDE_HIGH, 8'hA5);
            bus(1'b1, IDX_STATUS, 8'h18);
            for (int p = 0; p < 32; p++)
            begin
                i_pins.cap_drive(!p[0]);
                rises += !p[0];
                e = cap_exp(m[1:0], !p[0], rises);
                bus(1'b0, IDX_STATUS, 8'h00);
                `CHK(rd[4:3], {e, e})
                bus(1'b1, IDX_STATUS, 8'h18);
            end
            rdchk(IDX_CAPB_LOW, 8'(8'h30 + m));
            rdchk(IDX_CAPB_HIGH, 8'hA5);
            rdchk(IDX_WPCA_LOW, 8'(8'h30 + m));
            rdchk(IDX_WPCA_HIGH, 8'hA5);
        end
        end_sim();
    end
endmodule // timers_and_captures_test
`default_nettype wire
